// >>> rtl/isc_pkg.sv
package isc_pkg;

	// ************************************************************
	// Register map
	// ************************************************************
	localparam logic [7:0] ISC_CTRL_ADDR     = 8'h1a;  // Control word
	localparam logic [7:0] ISC_MASK_ADDR     = 8'h1e;  // Alarm mask word
	localparam logic [7:0] ISC_VECTOR_ADDR   = 8'h1f;  // Vector read-back
	localparam logic [7:0] ISC_CTRL_RESET    = 8'h00;
	localparam logic [7:0] ISC_MASK_RESET    = 8'h00;

	// ************************************************************
	// Control word fields
	// ************************************************************
	localparam int ISC_BIT_OUT_EN     = 7;
	localparam int ISC_BIT_SUSPEND    = 6;
	localparam int ISC_BIT_ACK        = 5;
	localparam int ISC_BIT_TX_CCS     = 4;
	localparam int ISC_BIT_REG_SIG    = 3;
	localparam int ISC_BIT_CNT_CLR    = 2;
	localparam int ISC_BIT_NIB_UPPER  = 1;
	localparam int ISC_BIT_CCS_LOW    = 0;

	// ************************************************************
	// Mask word fields
	// ************************************************************
	localparam int ISC_BIT_SYNC_LOSS  = 7;
	localparam int ISC_BIT_REMOTE     = 6;
	localparam int ISC_BIT_ALL_ONES   = 5;
	localparam int ISC_BIT_SLOT16     = 4;
	localparam int ISC_BIT_SIG_LOSS   = 3;
	localparam int ISC_BIT_FRAME_ERR  = 2;
	localparam int ISC_BIT_VIOL_OVF   = 1;
	localparam int ISC_BIT_SLIP       = 0;

	// ************************************************************
	// Vectors
	// ************************************************************
	localparam logic [7:0] ISC_VEC_SYNC   = 8'h80;  // 10000000
	localparam logic [7:0] ISC_VEC_ALARM  = 8'h40;  // 01000000
	localparam logic [7:0] ISC_VEC_FRAME  = 8'h20;  // 00100000
	localparam logic [7:0] ISC_VEC_OVF    = 8'h10;  // 00010000
	localparam logic [7:0] ISC_VEC_SLIP   = 8'h04;  // 00000100

	// ************************************************************
	// Timing: 4 MHz backplane clock, 8 bits per channel
	// ************************************************************
	localparam int ISC_C4_PER_BIT     = 2;     // Two 4 MHz ticks per bit
	localparam int ISC_C4_PER_CHAN    = 16;    // 8 bits per channel
	localparam int ISC_CHAN_PER_CYCLE = 4;     // One 64 kHz period
	localparam int ISC_CCS_RISE_CHAN  = 1;     // Rise after channel 1 mod 4
	localparam logic [7:0] ISC_VIOL_MAX = 8'hff;
	localparam logic [15:0] ISC_VIOL_WRAP = 16'hffff;

	// Alarm inputs from the framer
	typedef struct packed
	{
		logic sync_loss;
		logic remote_alarm;
		logic all_ones;
		logic slot16_all_ones;
		logic signal_loss;
		logic frame_error;
		logic slip;
		logic crc_sync_loss;
	} isc_alarm_s;

	// Register access bundle
	typedef struct packed
	{
		logic       cs;
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} isc_reg_req_s;

endpackage

// >>> rtl/isc_sync3.sv
// ************************************************************
// Three-stage synchroniser with agreement filter
// ************************************************************
module isc_sync3
	import isc_pkg::*;
#(
	parameter int W = 1
)
(
	input  wire logic         mclk,
	input  wire logic         rst_n,
	input  wire logic         ce,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] stage1;   // Metastable stage, read only by stage2
	logic [W-1:0] stage2;
	logic [W-1:0] stage3;

	// Change counts only when stages two and three agree
	wire  [W-1:0] agree = ~(stage2 ^ stage3);
	wire  [W-1:0] next_sync_out = (agree & stage3) | (~agree & sync_out);

	// Shift chain
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			stage1   <= '0;
			stage2   <= '0;
			stage3   <= '0;
			sync_out <= '0;
		end
		else if (ce)
		begin
			stage1   <= async_in;
			stage2   <= stage1;
			stage3   <= stage2;
			sync_out <= next_sync_out;
		end
	end

endmodule

// >>> rtl/isc_top.sv
// Contract
// - Output enable zero tristates data and signalling
// - Suspend floats request and ignores all sources
// - Any acknowledge toggle clears pending request unless a source is live in the same cycle
// - Transmit signalling mode selects CCS or CAS
// - CAS sourced from register page or stream
// - Counter clear zeros and holds status counters
// - Nibble bit picks upper or lower half
// - Low-rate CCS uses divided 64 kHz clock
// - Transmit clock rises after channels 1 mod 4
// - Receive CCS clock from extracted line timebase
// - Without low-rate CCS streams run full rate
// - Mask zero enables source; reset enables all
// - Frame sync loss gives vector 10000000
// - Remote, all-ones, slot16 give vector 01000000
// - Signal loss gives vector 01000000
// - Frame alignment error gives vector 00100000
// - Violation counter wrap gives vector 00010000
// - Frame slip gives vector 00000100
// - Conditional per-stream data output disable
module isc_top
	import isc_pkg::*;
(
	input  wire logic         mclk,
	input  wire logic         rst_n,
	input  wire logic         ce,
	// Host register port
	input  wire isc_reg_req_s reg_req,
	output logic        [7:0] reg_rdata,
	// Framer alarm and event inputs, asynchronous
	input  wire isc_alarm_s   alarm_in,
	input  wire logic         violation_pulse,
	// Per-stream conditional disables
	input  wire logic         data_out_cond_disable,
	input  wire logic         signalling_out_cond_disable,
	input  wire logic         mframe_sync_loss,
	// Backplane and line timing, sampled
	input  wire logic         backplane_4mhz_clock,
	input  wire logic         backplane_frame_pulse,
	input  wire logic         line_2mhz_clock,
	input  wire logic         line_frame_pulse,
	// Streams
	input  wire logic         backplane_data_src,
	input  wire logic         backplane_signalling_in,
	input  wire logic         page5_signalling_bit,
	output logic              backplane_data_out,
	output logic              backplane_data_out_oe,
	output logic              backplane_signalling_out,
	output logic              backplane_signalling_out_oe,
	// Interrupt request, open drain
	output logic              irq_n_out,
	output logic              irq_n_oe,
	output logic        [7:0] irq_vector,
	// Control indications to the framer
	output logic              tx_common_signalling_sel,
	output logic              register_sourced_signalling,
	output logic              status_counter_clear,
	output logic              signalling_nibble_upper,
	output logic              ccs_low_rate_sel,
	output logic              tx_ccs_clock,
	output logic              rx_ccs_clock_out,
	output logic              rx_ccs_clock_oe,
	output logic       [15:0] violation_count
);

	// ************************************************************
	// Registers
	// ************************************************************
	logic [7:0] ctrl;          // Control word
	logic [7:0] alarm_interrupt_mask;
	logic       ack_seen;      // Last acknowledge level
	logic       pending;       // Request pending
	logic [7:0] vector;        // Latched vector bits

	// ************************************************************
	// Synchronised inputs
	// ************************************************************
	isc_alarm_s alarm_s;
	logic [5:0] tim_s;
	logic       viol_wrap;

	isc_sync3 #(.W(8)) u_sync_alarm
	(
		.mclk     (mclk),
		.rst_n    (rst_n),
		.ce       (ce),
		.async_in (alarm_in),
		.sync_out (alarm_s)
	);

	isc_sync3 #(.W(6)) u_sync_timing
	(
		.mclk     (mclk),
		.rst_n    (rst_n),
		.ce       (ce),
		.async_in ({backplane_4mhz_clock, backplane_frame_pulse, line_2mhz_clock,
		            line_frame_pulse, violation_pulse, backplane_signalling_in}),
		.sync_out (tim_s)
	);

	wire c4_s   = tim_s[5];
	wire bfp_s  = tim_s[4];
	wire lck_s  = tim_s[3];
	wire lfp_s  = tim_s[2];
	wire vio_s  = tim_s[1];
	wire sig_in = tim_s[0];

	// Edge detect on synchronised copies only
	logic c4_d, lck_d, vio_d;
	wire  c4_fall  = c4_d & ~c4_s;
	wire  lck_fall = lck_d & ~lck_s;
	wire  vio_rise = vio_s & ~vio_d;

	// Counter zeroed and held while clear stands
	isc_viol_cnt u_viol
	(
		.mclk  (mclk),
		.rst_n (rst_n),
		.ce    (ce),
		.clr   (ctrl[ISC_BIT_CNT_CLR]),
		.inc   (vio_rise),
		.count (violation_count),
		.wrap  (viol_wrap)
	);

	// ************************************************************
	// Register decode
	// ************************************************************
	wire wr_ctrl = reg_req.cs && reg_req.wr && (reg_req.addr == ISC_CTRL_ADDR);
	wire wr_mask = reg_req.cs && reg_req.wr && (reg_req.addr == ISC_MASK_ADDR);
	wire [7:0] rd_mux = (reg_req.addr == ISC_CTRL_ADDR)   ? ctrl :
	                    (reg_req.addr == ISC_MASK_ADDR)   ? alarm_interrupt_mask :
	                    (reg_req.addr == ISC_VECTOR_ADDR) ? vector : 8'h00;

	// Storage of control and mask words
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			ctrl                 <= ISC_CTRL_RESET;
			alarm_interrupt_mask <= ISC_MASK_RESET;
			reg_rdata            <= 8'h00;
		end
		else if (ce)
		begin
			if (wr_ctrl)
				ctrl <= reg_req.wdata;
			if (wr_mask)
				alarm_interrupt_mask <= reg_req.wdata;
			reg_rdata <= reg_req.cs ? rd_mux : 8'h00;
		end
	end

	// ************************************************************
	// Interrupt sources
	// ************************************************************
	// Zero in a mask bit enables its source
	wire [7:0] en = ~alarm_interrupt_mask;
	wire [7:0] src_vec =
		((alarm_s.sync_loss       & en[ISC_BIT_SYNC_LOSS]) ? ISC_VEC_SYNC  : 8'h00) |
		((alarm_s.remote_alarm    & en[ISC_BIT_REMOTE])    ? ISC_VEC_ALARM : 8'h00) |
		((alarm_s.all_ones        & en[ISC_BIT_ALL_ONES])  ? ISC_VEC_ALARM : 8'h00) |
		((alarm_s.slot16_all_ones & en[ISC_BIT_SLOT16])    ? ISC_VEC_ALARM : 8'h00) |
		((alarm_s.signal_loss     & en[ISC_BIT_SIG_LOSS])  ? ISC_VEC_ALARM : 8'h00) |
		((alarm_s.frame_error     & en[ISC_BIT_FRAME_ERR]) ? ISC_VEC_FRAME : 8'h00) |
		((viol_wrap               & en[ISC_BIT_VIOL_OVF])  ? ISC_VEC_OVF   : 8'h00) |
		((alarm_s.slip            & en[ISC_BIT_SLIP])      ? ISC_VEC_SLIP  : 8'h00);

	// Suspend blocks every source at the door
	wire [7:0] live_vec = ctrl[ISC_BIT_SUSPEND] ? 8'h00 : src_vec;
	// Toggle in either direction acknowledges
	wire ack_toggle = ctrl[ISC_BIT_ACK] ^ ack_seen;
	// New source wins over a same-cycle acknowledge
	wire next_pending = (live_vec != 8'h00) | (pending & ~ack_toggle & ~ctrl[ISC_BIT_SUSPEND]);
	wire [7:0] next_vector = live_vec | ((ack_toggle | ctrl[ISC_BIT_SUSPEND]) ? 8'h00 : vector);

	// Pending flag and vector accumulate
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			ack_seen  <= 1'b0;
			pending   <= 1'b0;
			vector    <= 8'h00;
			irq_n_out <= 1'b1;
			irq_n_oe  <= 1'b0;
			irq_vector <= 8'h00;
		end
		else if (ce)
		begin
			ack_seen   <= ctrl[ISC_BIT_ACK];
			pending    <= next_pending;
			vector     <= next_vector;
			irq_vector <= next_vector;
			irq_n_out  <= 1'b0;
			// Open drain: drive low only while pending, float under suspend
			irq_n_oe   <= next_pending & ~ctrl[ISC_BIT_SUSPEND];
		end
	end

	// ************************************************************
	// Backplane and line timing: channel and bit position
	// ************************************************************
	logic [3:0] c4_cnt;    // 4 MHz ticks within a channel
	logic [4:0] chan;      // Channel number 0..31
	logic [3:0] l_cnt;     // Line bits within a channel
	logic [4:0] l_chan;

	// Channel counters reset by frame pulses
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			c4_d   <= 1'b0;
			lck_d  <= 1'b0;
			vio_d  <= 1'b0;
			c4_cnt <= 4'h0;
			chan   <= 5'h00;
			l_cnt  <= 4'h0;
			l_chan <= 5'h00;
		end
		else if (ce)
		begin
			c4_d  <= c4_s;
			lck_d <= lck_s;
			vio_d <= vio_s;
			if (c4_fall)
			begin
				if (bfp_s)
				begin
					c4_cnt <= 4'h0;
					chan   <= 5'h00;
				end
				else
				begin
					c4_cnt <= c4_cnt + 4'h1;
					if (c4_cnt == 4'(ISC_C4_PER_CHAN - 1))
						chan <= chan + 5'h01;
				end
			end
			if (lck_fall)
			begin
				if (lfp_s)
				begin
					l_cnt  <= 4'h0;
					l_chan <= 5'h00;
				end
				else
				begin
					// Eight line bits per channel, so the count wraps early
					if (l_cnt == 4'(ISC_C4_PER_CHAN / ISC_C4_PER_BIT - 1))
					begin
						l_cnt  <= 4'h0;
						l_chan <= l_chan + 5'h01;
					end
					else
						l_cnt <= l_cnt + 4'h1;
				end
			end
		end
	end

	// 64 kHz clocks: high for channels 2,3 mod 4, rising at 1->2 boundary
	wire tx64 = (chan[1:0] == 2'(ISC_CCS_RISE_CHAN + 1)) ||
	            (chan[1:0] == 2'(ISC_CCS_RISE_CHAN + 2));
	wire rx64 = (l_chan[1:0] == 2'(ISC_CCS_RISE_CHAN + 1)) ||
	            (l_chan[1:0] == 2'(ISC_CCS_RISE_CHAN + 2));
	wire bit_edge = c4_fall & c4_cnt[0];        // One bit per two ticks (2.048 Mb/s)
	wire slot_upper = ~c4_cnt[3];               // First four bits are upper nibble

	// ************************************************************
	// Stream output path
	// ************************************************************
	wire low_rate = ctrl[ISC_BIT_CCS_LOW];
	wire nib_ok   = ctrl[ISC_BIT_NIB_UPPER] ? slot_upper : ~slot_upper;
	wire cas_bit  = ctrl[ISC_BIT_REG_SIG] ? page5_signalling_bit : sig_in;
	wire sig_bit  = (ctrl[ISC_BIT_TX_CCS] | low_rate) ? sig_in : (nib_ok ? cas_bit : 1'b1);
	wire ccs_edge = tx64 & ~tx_ccs_clock;
	// Low rate updates once per 64 kHz period, else every bit
	wire sig_upd  = low_rate ? ccs_edge : bit_edge;
	wire data_dis = data_out_cond_disable & (alarm_s.signal_loss | alarm_s.sync_loss |
	                alarm_s.crc_sync_loss | alarm_s.all_ones);
	wire sig_dis  = signalling_out_cond_disable & (mframe_sync_loss | alarm_s.slot16_all_ones);
	wire out_en   = ctrl[ISC_BIT_OUT_EN];

	// Output registers
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			backplane_data_out          <= 1'b1;
			backplane_data_out_oe       <= 1'b0;
			backplane_signalling_out    <= 1'b1;
			backplane_signalling_out_oe <= 1'b0;
			tx_ccs_clock                <= 1'b0;
			rx_ccs_clock_out            <= 1'b0;
			rx_ccs_clock_oe             <= 1'b0;
			tx_common_signalling_sel    <= 1'b0;
			register_sourced_signalling <= 1'b0;
			status_counter_clear        <= 1'b0;
			signalling_nibble_upper     <= 1'b0;
			ccs_low_rate_sel            <= 1'b0;
		end
		else if (ce)
		begin
			if (bit_edge)
				backplane_data_out <= backplane_data_src;
			if (sig_upd)
				backplane_signalling_out <= sig_bit;
			backplane_data_out_oe       <= out_en & ~data_dis;
			backplane_signalling_out_oe <= out_en & ~sig_dis;
			tx_ccs_clock                <= tx64;
			rx_ccs_clock_out            <= rx64;
			rx_ccs_clock_oe             <= low_rate;
			tx_common_signalling_sel    <= ctrl[ISC_BIT_TX_CCS];
			register_sourced_signalling <= ctrl[ISC_BIT_REG_SIG];
			status_counter_clear        <= ctrl[ISC_BIT_CNT_CLR];
			signalling_nibble_upper     <= ctrl[ISC_BIT_NIB_UPPER];
			ccs_low_rate_sel            <= low_rate;
		end
	end

endmodule

// >>> rtl/isc_viol_cnt.sv
// ************************************************************
// Sixteen-bit violation counter with wrap pulse
// ************************************************************
module isc_viol_cnt
	import isc_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic        ce,
	input  wire logic        clr,
	input  wire logic        inc,
	output logic      [15:0] count,
	output logic             wrap
);

	wire        at_top = (count == ISC_VIOL_WRAP);
	wire [15:0] next_count = clr ? 16'h0000 : (inc ? count + 16'h0001 : count);

	// Counter held at zero while clear stands
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			count <= 16'h0000;
			wrap  <= 1'b0;
		end
		else if (ce)
		begin
			count <= next_count;
			wrap  <= !clr && inc && at_top;   // FFFF to 0 step
		end
	end

endmodule

// >>> sim/interrupt_signalling_control_tb_top.sv
// ************************************************************
// Self-checking bench
// ************************************************************
module interrupt_signalling_control_tb_top
	import isc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic         mclk = 1'b0;
	logic         rst_n = 1'b0;
	isc_reg_req_s reg_req = '0;
	isc_alarm_s   alarm_in = '0;
	logic         violation_pulse = 1'b0;
	logic         data_out_cond_disable = 1'b0;
	logic         sel_rx = 1'b0;   // Period check watches the receive clock
	logic [7:0]   ctrl_v = 8'h00;  // Control word last written
	logic [7:0]   got;
	int           err_total = 0;
	int           n_checks = 0;
	int           cycles = 0;
	int           n;
	wire logic [7:0]  reg_rdata, irq_vector;
	wire logic [15:0] violation_count;
	wire logic        backplane_data_out_oe, backplane_signalling_out_oe, irq_n_oe, tx_ccs_clock;
	wire logic        tx_common_signalling_sel, register_sourced_signalling, status_counter_clear;
	wire logic        signalling_nibble_upper, ccs_low_rate_sel, rx_ccs_clock_out, rx_ccs_clock_oe;
	wire logic        backplane_4mhz_clock, backplane_frame_pulse, line_2mhz_clock, line_frame_pulse;
	wire logic        backplane_signalling_in;
	wire logic        data_o, sig_o;   // Stream outputs
	logic             src_bit = 1'b0;  // Data and page bit source
	wire logic [4:0]  copies = {tx_common_signalling_sel, register_sourced_signalling,
		status_counter_clear, signalling_nibble_upper, ccs_low_rate_sel};
	wire logic        clk_sel = sel_rx ? rx_ccs_clock_out : tx_ccs_clock;
	// Rows: control word and {data oe, signalling oe, mode copies}
	logic [7:0] row_c [6] = '{8'h00, 8'h80, 8'h91, 8'h8a, 8'h04, 8'h9f};
	logic [6:0] row_e [6] = '{7'h00, 7'h60, 7'h71, 7'h6a, 7'h04, 7'h7f};
	// Sources, their mask bits and vectors
	logic [7:0] src_b [7] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04, 8'h02};
	logic [7:0] msk_b [7] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04, 8'h01};
	logic [7:0] vec_b [7] = '{8'h80, 8'h40, 8'h40, 8'h40, 8'h40, 8'h20, 8'h04};
	isc_top DUT
	(
		.mclk, .rst_n, .ce(1'b1), .reg_req, .reg_rdata, .alarm_in, .violation_pulse,
		.data_out_cond_disable, .signalling_out_cond_disable(1'b0), .mframe_sync_loss(1'b0),
		.backplane_4mhz_clock, .backplane_frame_pulse, .line_2mhz_clock, .line_frame_pulse,
		.backplane_data_src(src_bit), .backplane_signalling_in, .page5_signalling_bit(src_bit),
		.backplane_data_out(data_o), .backplane_data_out_oe, .backplane_signalling_out(sig_o),
		.backplane_signalling_out_oe, .irq_n_out(), .irq_n_oe, .irq_vector, .tx_common_signalling_sel,
		.register_sourced_signalling, .status_counter_clear, .signalling_nibble_upper,
		.ccs_low_rate_sel, .tx_ccs_clock, .rx_ccs_clock_out, .rx_ccs_clock_oe, .violation_count
	);
	isc_timing_model u_far
	(
		.backplane_4mhz_clock, .backplane_frame_pulse, .line_2mhz_clock, .line_frame_pulse,
		.backplane_signalling_in
	);
	always #10 mclk = ~mclk;
	// Hang guard, far above the few thousand cycles the run needs
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			err_total++;
			stop_test();
		end
	end
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk_v(input logic [15:0] g, input logic [15:0] e);
		n_checks++;
		if (g !== e)
		begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic chk_b(input logic g, input logic e);
		chk_v({15'h0000, g}, {15'h0000, e});
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge mclk);
		#2;
	endtask
	// Request held to its sampling edge, then an idle edge before the next
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		reg_req = '{1'b1, 1'b1, a, d};
		cyc(1);
		reg_req.cs = 1'b0;
		cyc(1);
	endtask
	task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
		reg_req = '{1'b1, 1'b0, a, 8'h00};
		cyc(1);
		d = reg_rdata;
		reg_req.cs = 1'b0;
		cyc(1);
	endtask
	task automatic wait_oe(input logic e);
		for (int k = 0; k < 20 && irq_n_oe !== e; k++)
			cyc(1);
	endtask
	task automatic pulse();
		violation_pulse = 1'b1;
		cyc(6);
		violation_pulse = 1'b0;
		cyc(8);
	endtask
	// Cycles until the selected clock next rises
	task automatic rise(output int c);
		logic p;
		p = clk_sel;
		for (c = 0; c < 2000 && !(clk_sel === 1'b1 && p === 1'b0); c++)
		begin
			p = clk_sel;
			cyc(1);
		end
	endtask
	initial
	begin
		cyc(8);
		rst_n = 1'b1;
		chk_v({backplane_data_out_oe, backplane_signalling_out_oe, irq_n_oe}, 3'h0);
		reg_rd(ISC_CTRL_ADDR, got);
		chk_v(got, ISC_CTRL_RESET);
		reg_rd(ISC_MASK_ADDR, got);
		chk_v(got, ISC_MASK_RESET);
		reg_rd(8'h55, got);
		chk_v(got, 8'h00);
		// Control word table
		for (int i = 0; i < 6; i++)
		begin
			reg_wr(ISC_CTRL_ADDR, row_c[i]);
			cyc(2);
			chk_v({backplane_data_out_oe, backplane_signalling_out_oe, copies}, row_e[i]);
			reg_rd(ISC_CTRL_ADDR, got);
			chk_v(got, row_c[i]);
		end
		reg_wr(ISC_CTRL_ADDR, ctrl_v);
		// Seven alarm sources (not the violation wrap) masked, then unmasked, then acknowledged
		for (int i = 0; i < 7; i++)
		begin
			reg_wr(ISC_MASK_ADDR, msk_b[i]);
			alarm_in = src_b[i];
			cyc(12);
			chk_b(irq_n_oe, 1'b0);
			reg_wr(ISC_MASK_ADDR, 8'h00);
			wait_oe(1'b1);
			chk_b(irq_n_oe, 1'b1);
			chk_v(irq_vector, vec_b[i]);
			reg_rd(ISC_VECTOR_ADDR, got);
			chk_v(got, vec_b[i]);
			cyc(6);
			alarm_in = '0;
			cyc(10);
			ctrl_v ^= 8'h20;
			reg_wr(ISC_CTRL_ADDR, ctrl_v);
			chk_b(irq_n_oe, 1'b0);
		end
		// Suspended sources leave nothing pending
		ctrl_v ^= 8'h40;
		reg_wr(ISC_CTRL_ADDR, ctrl_v);
		alarm_in = 8'h80;
		cyc(12);
		chk_b(irq_n_oe, 1'b0);
		alarm_in = '0;
		cyc(10);
		ctrl_v ^= 8'h40;
		reg_wr(ISC_CTRL_ADDR, ctrl_v);
		cyc(2);
		chk_b(irq_n_oe, 1'b0);
		// Conditional data disable needs the global enable
		reg_wr(ISC_MASK_ADDR, 8'hff);
		ctrl_v ^= 8'h80;
		reg_wr(ISC_CTRL_ADDR, ctrl_v);
		data_out_cond_disable = 1'b1;
		alarm_in = 8'h08;
		cyc(12);
		chk_v({backplane_data_out_oe, backplane_signalling_out_oe}, 2'h1);
		alarm_in = '0;
		cyc(12);
		chk_b(backplane_data_out_oe, 1'b1);
		data_out_cond_disable = 1'b0;
		ctrl_v ^= 8'h80;
		reg_wr(ISC_CTRL_ADDR, ctrl_v);
		reg_wr(ISC_MASK_ADDR, 8'h00);
		// Counter counts, is held at zero while cleared, then resumes
		repeat (3) pulse();
		chk_v(violation_count, 16'h0003);
		ctrl_v ^= 8'h04;
		reg_wr(ISC_CTRL_ADDR, ctrl_v);
		pulse();
		chk_v(violation_count, 16'h0000);
		ctrl_v ^= 8'h04;
		reg_wr(ISC_CTRL_ADDR, ctrl_v);
		pulse();
		chk_v(violation_count, 16'h0001);
		// Register-sourced CAS: a zero page bit shows only inside the chosen nibble
		ctrl_v ^= 8'h08;
		reg_wr(ISC_CTRL_ADDR, ctrl_v);
		for (int v = 0; v < 2; v++)
		begin
			src_bit = v[0];
			cyc(40);
			n = 0;
			repeat (800)
			begin
				cyc(1);
				n += !sig_o;
			end
			chk_b(n > 0, !src_bit);
			chk_b(data_o, src_bit);
		end
		ctrl_v ^= 8'h08;
		reg_wr(ISC_CTRL_ADDR, ctrl_v);
		// Low-rate clocks: four channels of 16 ticks, about 781 cycles
		ctrl_v ^= 8'h01;
		reg_wr(ISC_CTRL_ADDR, ctrl_v);
		rise(n);
		rise(n);
		chk_b(n >= 777 && n <= 785, 1'b1);
		sel_rx = 1'b1;
		rise(n);
		rise(n);
		chk_b(n >= 777 && n <= 785, 1'b1);
		chk_b(rx_ccs_clock_oe, 1'b1);
		ctrl_v ^= 8'h01;
		reg_wr(ISC_CTRL_ADDR, ctrl_v);
		cyc(3);
		chk_b(rx_ccs_clock_oe, 1'b0);
		stop_test();
	end
endmodule

// >>> sim/isc_checker_assertions.sv
// ************************************************************
// Port checks for interrupt and signalling control
// ************************************************************
module isc_checker
	import isc_pkg::*;
(
	input wire logic         mclk,
	input wire logic         rst_n,
	input wire isc_reg_req_s reg_req,
	input wire isc_alarm_s   alarm_in,
	input wire logic         violation_pulse,
	input wire logic         backplane_data_out_oe,
	input wire logic         backplane_signalling_out_oe,
	input wire logic         irq_n_out,
	input wire logic         irq_n_oe,
	input wire logic [7:0]   irq_vector,
	input wire logic         tx_common_signalling_sel,
	input wire logic         register_sourced_signalling,
	input wire logic         status_counter_clear,
	input wire logic         signalling_nibble_upper,
	input wire logic         ccs_low_rate_sel,
	input wire logic         rx_ccs_clock_oe,
	input wire logic [15:0]  violation_count
);
	logic [7:0] ctrl;   // Control word as written
	logic [7:0] mask;   // Mask word as written
	logic [3:0] quiet;  // Idle cycles of every source, saturating
	wire        wr_go = reg_req.cs && reg_req.wr;
	wire        busy  = alarm_in != 8'h00 || violation_pulse;
	wire [4:0]  copies = {tx_common_signalling_sel, register_sourced_signalling, status_counter_clear,
		signalling_nibble_upper, ccs_low_rate_sel};
	// Shadow host writes; clock enable is assumed high, so it is not watched
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			ctrl  <= ISC_CTRL_RESET;
			mask  <= ISC_MASK_RESET;
			quiet <= 4'h0;
		end
		else
		begin
			if (wr_go && reg_req.addr == ISC_CTRL_ADDR)
				ctrl <= reg_req.wdata;
			if (wr_go && reg_req.addr == ISC_MASK_ADDR)
				mask <= reg_req.wdata;
			quiet <= busy ? 4'h0 : quiet + {3'h0, quiet != 4'hf};
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	a_streams_tristate: assert property (
		!ctrl[7] && !$past(ctrl[7]) |-> !backplane_data_out_oe && !backplane_signalling_out_oe)
		else $error("stream driver on while disabled");
	a_suspend_floats: assert property (ctrl[6] && $past(ctrl[6]) |-> !irq_n_oe)
		else $error("request driven while suspended");
	a_mode_copies: assert property (copies == $past(ctrl[4:0]))
		else $error("mode outputs differ from control word");
	a_ack_release: assert property (
		$changed(ctrl[5]) && quiet >= 4'h8 && !ctrl[6] |=> !irq_n_oe)
		else $error("request not released by acknowledge");
	a_irq_holds: assert property (irq_n_oe && !$changed(ctrl[5]) && !ctrl[6] |=> irq_n_oe)
		else $error("request dropped without acknowledge");
	a_irq_low: assert property (irq_n_oe |-> !irq_n_out)
		else $error("request pin not driven low");
	a_sync_vector: assert property (
		(alarm_in.sync_loss && !mask[7] && !ctrl[6]) [*6] |-> ##[0:3] (irq_n_oe && irq_vector[7]))
		else $error("sync loss gave no request");
	a_clear_zero: assert property (
		status_counter_clear && $past(status_counter_clear) |-> violation_count == 16'h0000)
		else $error("counter not held at zero");
	a_rx_clk_oe: assert property (
		ccs_low_rate_sel == $past(ccs_low_rate_sel) && ccs_low_rate_sel == $past(ccs_low_rate_sel, 2)
		|-> rx_ccs_clock_oe == ccs_low_rate_sel)
		else $error("receive clock drive wrong");
	c_ack_seen: cover property ($changed(ctrl[5]) && irq_n_oe);
	c_sync_irq: cover property (irq_n_oe && irq_vector[7]);
	c_count_clear: cover property (status_counter_clear && $past(violation_count) != 16'h0000);
endmodule

bind isc_top isc_checker u_chk
(
	.mclk, .rst_n, .reg_req, .alarm_in, .violation_pulse, .backplane_data_out_oe,
	.backplane_signalling_out_oe, .irq_n_out, .irq_n_oe, .irq_vector, .tx_common_signalling_sel,
	.register_sourced_signalling, .status_counter_clear, .signalling_nibble_upper,
	.ccs_low_rate_sel, .rx_ccs_clock_oe, .violation_count
);

// >>> sim/isc_timing_model.sv
// ************************************************************
// Backplane and line timing on the far side
// ************************************************************
module isc_timing_model
	import isc_pkg::*;
(
	output logic backplane_4mhz_clock,
	output logic backplane_frame_pulse,
	output logic line_2mhz_clock,
	output logic line_frame_pulse,
	output logic backplane_signalling_in
);
	timeunit 1ns;
	timeprecision 1ps;
	int n4 = 0;  // Backplane ticks into the frame
	int nl = 0;  // Line bits into the frame
	// Both timebases run free; frames of 512 and 256 ticks
	initial
	begin
		{backplane_4mhz_clock, backplane_frame_pulse, backplane_signalling_in} = 3'h4;
		{line_2mhz_clock, line_frame_pulse} = 2'h2;
	end
	always #122 backplane_4mhz_clock = ~backplane_4mhz_clock;
	always #244 line_2mhz_clock = ~line_2mhz_clock;
	// Pulse straddles the falling edge that opens channel 0; one stream bit per two ticks
	always @(posedge backplane_4mhz_clock)
	begin
		n4 = (n4 + 1) % 512;
		backplane_frame_pulse = n4 == 511;
		backplane_signalling_in = n4[1];
	end
	// Line frame marker
	always @(posedge line_2mhz_clock)
	begin
		nl = (nl + 1) % 256;
		line_frame_pulse = nl == 255;
	end
endmodule
